//--- core/ssc_ctrl.sv
// conversion sequencing, track-and-hold control and register slave
// Summary of operation
// - A rising group A start puts the track-and-holds of channels 1 to 4 into hold.
// - A rising group B start puts the track-and-holds of channels 5 to 8 into hold.
// - Conversion starts only once both starts have risen, busy rising on the later edge.
// - Both starts rising together hold all eight channels and raise busy at once.
// - The conversion clock is internal and all eight channels convert in 4 us.
// - Busy falls only after all eight channel conversions are finished.
// - When busy falls every track-and-hold returns to track.
// - New results read after busy falls; reads during busy return the previous set.
// - Range high gives a 10 V bipolar range on all channels, low gives 5 V.
// - A range change takes effect at once, though the host should keep it static.
// - Results are 14-bit twos complement, one step being full scale over 16384.
// - The step is 1.221 mV in the wide range and 0.610 mV in the narrow range.
// - Reference select high enables the internal reference, low disables it.
// - After reset the reference mode follows the reference select level.
`timescale 1ns/100ps
`include "ssc_defs.svh"
module ssc_ctrl (
  input  wire logic                                    clk_i,
  input  wire logic                                    reset_i,
  input  wire logic                                    group_a_sample_start_i,
  input  wire logic                                    group_b_sample_start_i,
  input  wire logic                                    range_sel_i,
  input  wire logic                                    ref_sel_i,
  input  wire logic [`SSC_NUM_CHAN*`SSC_CODE_W-1:0]    chan_code_i,
  input  wire logic [`SSC_ADDR_W-1:0]                  avs_address,
  input  wire logic                                    avs_read,
  input  wire logic                                    avs_write,
  input  wire logic [31:0]                             avs_writedata,
  output logic [31:0]                                  avs_readdata,
  output logic                                         avs_waitrequest,
  output logic                                         busy_o,
  output logic [`SSC_NUM_CHAN-1:0]                     hold_o,
  output logic                                         range_10v_o,
  output logic [`SSC_LSB_W-1:0]                        lsb_step_uv_o,
  output logic                                         int_ref_en_o,
  output logic                                         irq_o
);
  localparam int CONV_CYCLES = `SSC_TCONV_NS / `SSC_CLK_NS;
  localparam int CHAN_CYCLES = CONV_CYCLES / `SSC_NUM_CHAN;
  localparam int LAST_CONV   = CONV_CYCLES - 1;
  localparam int LAST_CHAN   = `SSC_NUM_CHAN - 1;
  localparam int HALF        = `SSC_NUM_CHAN / 2;
  // busy is sampled high on cycles 1 to 40 after its rise, low on cycle 41
  localparam int BUSY_TAIL   = CONV_CYCLES - 7;

  logic [3:0]                     pins_sync;
  logic                           start_a_q_ff;
  logic                           start_b_q_ff;
  logic                           rise_a;
  logic                           rise_b;
  ssc_pkg::ssc_state_t            state_ff;
  logic [5:0]                     conv_cnt_ff;
  logic [2:0]                     conv_chan_ff;
  logic [2:0]                     chan_cyc_ff;
  logic                           conv_done;
  logic [`SSC_CODE_W-1:0]         held_ff   [`SSC_NUM_CHAN];
  logic [`SSC_CODE_W-1:0]         result_ff [`SSC_NUM_CHAN];
  logic [`SSC_EV_W-1:0]           status_ff;
  logic [`SSC_EV_W-1:0]           mask_ff;
  logic [`SSC_EV_W-1:0]           events;
  logic                           ack_ff;
  logic                           access;
  logic                           accept;
  logic [31:0]                    nxt_readdata;

  // pins are asynchronous to clk_i
  ssc_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .clk_i  (clk_i),
    .reset_i(reset_i),
    .pin_i  ({ref_sel_i, range_sel_i, group_b_sample_start_i, group_a_sample_start_i}),
    .sync_o (pins_sync)
  );

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      start_a_q_ff <= 1'b0;
      start_b_q_ff <= 1'b0;
    end else begin
      start_a_q_ff <= pins_sync[0];
      start_b_q_ff <= pins_sync[1];
    end
  end

  assign rise_a = pins_sync[0] & ~start_a_q_ff;
  assign rise_b = pins_sync[1] & ~start_b_q_ff;

  function automatic logic [`SSC_CODE_W-1:0] chan_code(input logic [2:0] idx);
    chan_code = chan_code_i[idx*`SSC_CODE_W +: `SSC_CODE_W];
  endfunction

  // sequencing: both groups must be held before the converter runs
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_ff <= ssc_pkg::SSC_IDLE;
    end else begin
      case (state_ff)
        ssc_pkg::SSC_IDLE: begin
          if (rise_a && rise_b) begin
            state_ff <= ssc_pkg::SSC_CONV;
          end else if (rise_a) begin
            state_ff <= ssc_pkg::SSC_WAIT_B;
          end else if (rise_b) begin
            state_ff <= ssc_pkg::SSC_WAIT_A;
          end
        end
        ssc_pkg::SSC_WAIT_A: begin
          if (rise_a) begin
            state_ff <= ssc_pkg::SSC_CONV;
          end
        end
        ssc_pkg::SSC_WAIT_B: begin
          if (rise_b) begin
            state_ff <= ssc_pkg::SSC_CONV;
          end
        end
        ssc_pkg::SSC_CONV: begin
          if (conv_done) begin
            state_ff <= ssc_pkg::SSC_IDLE;
          end
        end
        default: begin
          state_ff <= ssc_pkg::SSC_IDLE;
        end
      endcase
    end
  end

  assign conv_done = (state_ff == ssc_pkg::SSC_CONV) && (conv_cnt_ff == 6'(LAST_CONV));

  // internal conversion clock: fixed cycle budget per channel
  always_ff @(posedge clk_i) begin
    if (reset_i || state_ff != ssc_pkg::SSC_CONV) begin
      conv_cnt_ff  <= '0;
      conv_chan_ff <= '0;
      chan_cyc_ff  <= '0;
    end else if (!conv_done) begin
      conv_cnt_ff <= conv_cnt_ff + 6'h01;
      if (chan_cyc_ff == 3'(CHAN_CYCLES - 1)) begin
        chan_cyc_ff  <= '0;
        conv_chan_ff <= conv_chan_ff + 3'h1;
      end else begin
        chan_cyc_ff <= chan_cyc_ff + 3'h1;
      end
    end
  end

  // busy rises on the edge that completes both holds, falls after the last channel
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      busy_o <= 1'b0;
    end else if (conv_done) begin
      busy_o <= 1'b0;
    end else if ((state_ff == ssc_pkg::SSC_IDLE && rise_a && rise_b) ||
                 (state_ff == ssc_pkg::SSC_WAIT_A && rise_a) ||
                 (state_ff == ssc_pkg::SSC_WAIT_B && rise_b)) begin
      busy_o <= 1'b1;
    end
  end

  // track-and-hold per channel; a repeat edge on an already held group is ignored
  for (genvar g = 0; g < `SSC_NUM_CHAN; g++) begin : g_th
    localparam bit GRP_B = (g >= HALF);
    logic take;
    assign take = (GRP_B ? rise_b : rise_a) && !hold_o[g] && state_ff != ssc_pkg::SSC_CONV;
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        hold_o[g]  <= 1'b0;
        held_ff[g] <= '0;
        result_ff[g] <= '0;
      end else begin
        if (conv_done) begin
          hold_o[g]    <= 1'b0;
          result_ff[g] <= held_ff[g];
        end else if (take) begin
          hold_o[g]  <= 1'b1;
          held_ff[g] <= chan_code(3'(g));
        end
      end
    end
  end

  // range and reference follow their pins continuously, also out of reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      range_10v_o   <= 1'b0;
      lsb_step_uv_o <= `SSC_LSB_NARROW_UV;
      int_ref_en_o  <= 1'b0;
    end else begin
      range_10v_o   <= pins_sync[2];
      lsb_step_uv_o <= pins_sync[2] ? `SSC_LSB_WIDE_UV : `SSC_LSB_NARROW_UV;
      int_ref_en_o  <= pins_sync[3];
    end
  end

  assign events[`SSC_EV_DONE]    = conv_done;
  assign events[`SSC_EV_HOLD_A]  = rise_a && state_ff != ssc_pkg::SSC_CONV;
  assign events[`SSC_EV_HOLD_B]  = rise_b && state_ff != ssc_pkg::SSC_CONV;
  // start edges during busy are dropped; flag them for software
  assign events[`SSC_EV_OVERRUN] = (rise_a || rise_b) && state_ff == ssc_pkg::SSC_CONV;

  // one wait state per access so read data come from a flip-flop
  assign access          = avs_read || avs_write;
  assign avs_waitrequest = access && !ack_ff;
  assign accept          = access && ack_ff;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= access && !ack_ff;
    end
  end

  always_comb begin
    nxt_readdata = 32'h0000_0000;
    if (avs_address >= `SSC_REG_RESULT0) begin
      // sign extension keeps the result twos complement in 32 bits
      nxt_readdata = 32'(signed'(result_ff[avs_address[2:0]]));
    end else begin
      case (avs_address)
        `SSC_REG_STATUS:   nxt_readdata = {28'h0, status_ff};
        `SSC_REG_MASK:     nxt_readdata = {28'h0, mask_ff};
        `SSC_REG_CONFIG:   nxt_readdata = {30'h0, int_ref_en_o, range_10v_o};
        `SSC_REG_PROGRESS: nxt_readdata = {20'h0, hold_o, conv_chan_ff, busy_o};
        default:           nxt_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_ff) begin
      avs_readdata <= nxt_readdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mask_ff <= `SSC_MASK_RESET;
    end else if (accept && avs_write && avs_address == `SSC_REG_MASK) begin
      mask_ff <= avs_writedata[`SSC_EV_W-1:0];
    end
  end

  // a read clears the status; a new event in the same cycle survives
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      status_ff <= '0;
    end else if (accept && avs_read && avs_address == `SSC_REG_STATUS) begin
      status_ff <= events;
    end else begin
      status_ff <= status_ff | events;
    end
  end

  assign irq_o = |(status_ff & mask_ff);

  a_hold_group_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (rise_a && state_ff != ssc_pkg::SSC_CONV) |=> &hold_o[HALF-1:0])
    else $error("group a not held after its start edge");
  a_hold_group_b: assert property (@(posedge clk_i) disable iff (reset_i)
    (rise_b && state_ff != ssc_pkg::SSC_CONV) |=> &hold_o[LAST_CHAN:HALF])
    else $error("group b not held after its start edge");
  a_busy_later_edge: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(busy_o) |-> &hold_o && $past(state_ff != ssc_pkg::SSC_CONV))
    else $error("busy rose before both groups were held");
  a_common_start: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_ff == ssc_pkg::SSC_IDLE && rise_a && rise_b) |=> busy_o && &hold_o)
    else $error("common start did not begin conversion");
  a_conv_time: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(busy_o) |-> busy_o [*8] ##BUSY_TAIL !busy_o)
    else $error("conversion time is not four microseconds");
  a_all_chans_done: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(busy_o) |-> $past(conv_chan_ff) == 3'(LAST_CHAN))
    else $error("busy fell before the last channel");
  a_track_on_fall: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(busy_o) |-> hold_o == '0)
    else $error("track-and-holds not back in track");
  a_results_stable: assert property (@(posedge clk_i) disable iff (reset_i)
    !$past(conv_done) |-> $stable(result_ff[0]) && $stable(result_ff[LAST_CHAN]))
    else $error("results changed outside end of conversion");
  a_range_step: assert property (@(posedge clk_i) disable iff (reset_i)
    lsb_step_uv_o == (range_10v_o ? `SSC_LSB_WIDE_UV : `SSC_LSB_NARROW_UV))
    else $error("code step does not match range");
  a_sign_extend: assert property (@(posedge clk_i) disable iff (reset_i)
    (accept && avs_read && avs_address >= `SSC_REG_RESULT0) |->
      (avs_readdata[31:`SSC_CODE_W] == {(32-`SSC_CODE_W){avs_readdata[`SSC_CODE_W-1]}}))
    else $error("result not sign extended");
  a_ref_follows: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(pins_sync[3]) |=> int_ref_en_o ##1 $past(int_ref_en_o))
    else $error("internal reference does not follow select");
  // refused starts, bus pacing and capture timing
  a_wait_no_busy: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_ff == ssc_pkg::SSC_WAIT_A || state_ff == ssc_pkg::SSC_WAIT_B) |-> !busy_o)
    else $error("busy high while one group still tracks");
  a_group_a_waits: assert property (@(posedge clk_i) disable iff (reset_i)
    state_ff == ssc_pkg::SSC_WAIT_B |-> (&hold_o[HALF-1:0]) && (hold_o[LAST_CHAN:HALF] == '0))
    else $error("wrong groups held while waiting for group b");
  a_hold_while_busy: assert property (@(posedge clk_i) disable iff (reset_i)
    busy_o |-> &hold_o)
    else $error("a channel left hold during conversion");
  a_start_dropped: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_ff == ssc_pkg::SSC_CONV && (rise_a || rise_b) && !conv_done) |=> busy_o)
    else $error("start edge during busy disturbed the conversion");
  a_overrun_flag: assert property (@(posedge clk_i) disable iff (reset_i)
    events[`SSC_EV_OVERRUN] |=> status_ff[`SSC_EV_OVERRUN])
    else $error("start edge during busy not flagged");
  a_capture_code: assert property (@(posedge clk_i) disable iff (reset_i)
    (rise_a && state_ff == ssc_pkg::SSC_IDLE) |=> held_ff[0] == $past(chan_code_i[`SSC_CODE_W-1:0]))
    else $error("channel code not captured at hold");
  a_results_new: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(busy_o) |-> result_ff[LAST_CHAN] == held_ff[LAST_CHAN])
    else $error("last result not updated at end of conversion");
  a_first_result: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(busy_o) |-> result_ff[0] == held_ff[0])
    else $error("first result not updated at end of conversion");
  a_one_wait: assert property (@(posedge clk_i) disable iff (reset_i)
    (access && avs_waitrequest) |=> (!access || !avs_waitrequest))
    else $error("access not answered after one wait state");
  a_irq_done: assert property (@(posedge clk_i) disable iff (reset_i)
    (conv_done && mask_ff[`SSC_EV_DONE]) |=> irq_o)
    else $error("no interrupt at end of conversion");
  a_range_follows: assert property (@(posedge clk_i) disable iff (reset_i)
    $changed(pins_sync[2]) |=> range_10v_o == $past(pins_sync[2]))
    else $error("range output lags its synchronised pin");

  c_common_start: cover property (@(posedge clk_i) disable iff (reset_i)
    state_ff == ssc_pkg::SSC_IDLE && rise_a && rise_b);
  c_staggered: cover property (@(posedge clk_i) disable iff (reset_i)
    state_ff == ssc_pkg::SSC_WAIT_A && rise_a);
  c_read_in_busy: cover property (@(posedge clk_i) disable iff (reset_i)
    busy_o && accept && avs_read && avs_address >= `SSC_REG_RESULT0);
  c_overrun: cover property (@(posedge clk_i) disable iff (reset_i)
    events[`SSC_EV_OVERRUN]);
  c_busy_fall: cover property (@(posedge clk_i) disable iff (reset_i)
    $fell(busy_o));
endmodule

//--- core/ssc_defs.svh
// constants for the simultaneous sample conversion control block
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH
`define SSC_CLK_NS        100
`define SSC_TCONV_NS      4000
`define SSC_NUM_CHAN      8
`define SSC_CODE_W        14
`define SSC_ADDR_W        4
`define SSC_REG_STATUS    4'h0
`define SSC_REG_MASK      4'h1
`define SSC_REG_CONFIG    4'h2
`define SSC_REG_PROGRESS  4'h3
`define SSC_REG_RESULT0   4'h8
`define SSC_EV_DONE       0
`define SSC_EV_HOLD_A     1
`define SSC_EV_HOLD_B     2
`define SSC_EV_OVERRUN    3
`define SSC_EV_W          4
`define SSC_MASK_RESET    4'h0
`define SSC_LSB_WIDE_UV   11'h4c5
`define SSC_LSB_NARROW_UV 11'h262
`define SSC_LSB_W         11
`endif

//--- core/ssc_pkg.sv
// types shared by the conversion control block
package ssc_pkg;
  typedef enum logic [1:0] {
    SSC_IDLE,
    SSC_WAIT_A,
    SSC_WAIT_B,
    SSC_CONV
  } ssc_state_t;
endpackage

//--- core/ssc_sync.sv
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
module ssc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule

//--- tb/ssc_host.sv
// host model driving the two group start pins and the channel codes
`timescale 1ns/100ps
module ssc_host (
  input  wire logic         clk_i,
  input  wire logic         busy_i,
  output logic              grp_a_o,
  output logic              grp_b_o,
  output logic [111:0]      code_o
);
  initial begin
    grp_a_o = 1'b0;
    grp_b_o = 1'b0;
    code_o  = '0;
  end
  // gap 0 means one common start edge, the only form allowed with oversampling
  task automatic fire(input int gap, input logic [111:0] codes);
    while (busy_i !== 1'b0) @(posedge clk_i);
    grp_a_o <= 1'b0;
    grp_b_o <= 1'b0;
    // pins must sit low a few cycles so the synchroniser sees a real rise
    repeat (3) @(posedge clk_i);
    code_o  <= codes;
    grp_a_o <= 1'b1;
    repeat (gap) @(posedge clk_i);
    grp_b_o <= 1'b1;
  endtask
  // a start edge during busy, against the host's own rule, to see it dropped
  task automatic restart_a();
    grp_a_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    grp_a_o <= 1'b1;
  endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench for the conversion control block
`timescale 1ns/100ps
`include "ssc_defs.svh"
module tb_top;
  logic         clk_i, reset_i, range_sel_i, ref_sel_i;
  logic         avs_read, avs_write, busy_o, range_10v_o, int_ref_en_o, irq_o;
  logic         avs_waitrequest, grp_a, grp_b, bz_q;
  logic [3:0]   avs_address;
  logic [31:0]  avs_writedata, avs_readdata;
  logic [7:0]   hold_o;
  logic [10:0]  lsb_step_uv_o;
  logic [111:0] codes, prev;
  logic [127:0] rnd;
  logic [31:0]  exp_q[$];
  int           bw_q[$];
  int           error_cnt, n_compared, seed, bcnt, r, f;
  wire logic [111:0] codes_w;

  ssc_ctrl DUT (.clk_i(clk_i), .reset_i(reset_i), .group_a_sample_start_i(grp_a),
    .group_b_sample_start_i(grp_b), .range_sel_i(range_sel_i), .ref_sel_i(ref_sel_i),
    .chan_code_i(codes_w), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .busy_o(busy_o), .hold_o(hold_o),
    .range_10v_o(range_10v_o), .lsb_step_uv_o(lsb_step_uv_o),
    .int_ref_en_o(int_ref_en_o), .irq_o(irq_o));
  ssc_host u_host (.clk_i(clk_i), .busy_i(busy_o), .grp_a_o(grp_a), .grp_b_o(grp_b),
    .code_o(codes_w));

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic av_rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i);
    avs_address <= a;
    avs_read    <= 1'b1;
    exp_q.push_back(e);
    do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
  endtask

  task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  function automatic logic [31:0] sx(input logic [13:0] c);
    return {{18{c[13]}}, c};
  endfunction

  task automatic conv(input int gap);
    prev = codes;
    rnd  = {$random(seed), $random(seed), $random(seed), $random(seed)};
    codes = rnd[111:0];
    bw_q.push_back(`SSC_TCONV_NS / `SSC_CLK_NS);
    u_host.fire(gap, codes);
    #1;
    cmp("hold_first", (gap > 0) ? 32'h0f : 32'h0, {24'h0, hold_o});
    cmp("busy_early", 32'h0, {31'h0, busy_o});
    repeat (3) @(posedge clk_i);
    #1;
    cmp("hold_all", 32'hff, {24'h0, hold_o});
    cmp("busy_rise", 32'h1, {31'h0, busy_o});
  endtask

  // read answers are compared when accepted
  always @(posedge clk_i) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) cmp("rd_queue", 32'h1, 32'h0);
      else cmp("readdata", exp_q.pop_front(), avs_readdata);
    end
  end

  // busy width and release of the track-and-holds at its fall
  always @(posedge clk_i) begin
    if (busy_o === 1'b1) begin
      bcnt++;
    end else if (bz_q === 1'b1) begin
      if (bw_q.size() == 0) cmp("bw_queue", 32'h1, 32'h0);
      else cmp("busy_width", bw_q.pop_front(), bcnt);
      cmp("hold_release", 32'h0, {24'h0, hold_o});
      bcnt = 0;
    end
    bz_q = busy_o;
  end

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    error_cnt++;
    complete_run();
  end

  initial begin
    {reset_i, range_sel_i, ref_sel_i, avs_read, avs_write} = 5'h10;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    codes = '0;
    bz_q = 1'b0;
    {error_cnt, n_compared, bcnt} = '0;
    seed = 84911;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    av_wr(`SSC_REG_MASK, 32'h1);
    av_rd(`SSC_REG_MASK, 32'h1);
    av_rd(4'h5, 32'h0);
    av_wr(4'h5, 32'hff);
    av_rd(`SSC_REG_MASK, 32'h1);
    conv(0);
    #1;
    cmp("irq_busy", 32'h0, {31'h0, irq_o});
    repeat (42) @(posedge clk_i);
    #1;
    cmp("irq_done", 32'h1, {31'h0, irq_o});
    for (int ch = 0; ch < 8; ch++) av_rd(`SSC_REG_RESULT0 + ch[3:0], sx(codes[ch*14 +: 14]));
    av_rd(`SSC_REG_STATUS, 32'h7);
    @(posedge clk_i);
    #1;
    cmp("irq_clear", 32'h0, {31'h0, irq_o});
    // staggered groups; the old set stays readable during busy
    conv(5);
    av_rd(`SSC_REG_RESULT0, sx(prev[13:0]));
    // fifth conversion cycle: channel 0 running, all held, busy
    av_rd(`SSC_REG_PROGRESS, 32'h0000_0ff1);
    u_host.restart_a();
    repeat (42) @(posedge clk_i);
    av_rd(`SSC_REG_RESULT0 + 4'h7, sx(codes[111:98]));
    av_rd(`SSC_REG_STATUS, 32'h0000_000f);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      f = $random(seed);
      @(posedge clk_i);
      range_sel_i <= r[0];
      ref_sel_i   <= f[0];
      repeat (4) @(posedge clk_i);
      #1;
      cmp("range", {31'h0, r[0]}, {31'h0, range_10v_o});
      cmp("lsb", r[0] ? `SSC_LSB_WIDE_UV : `SSC_LSB_NARROW_UV, lsb_step_uv_o);
      cmp("int_ref", {31'h0, f[0]}, {31'h0, int_ref_en_o});
      av_rd(`SSC_REG_CONFIG, {30'h0, f[0], r[0]});
    end
    @(posedge clk_i);
    ref_sel_i <= 1'b1;
    reset_i   <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    cmp("ref_after_reset", 32'h1, {31'h0, int_ref_en_o});
    repeat (2) @(posedge clk_i);
    complete_run();
  end
endmodule
